// >>> shared/cckr_pkg.sv
package cckr_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Map bases: direct map, indirect map, extra block registers
    localparam logic [11:0] DIR_BASE = 12'h000;
    localparam logic [11:0] IND_BASE = 12'h400;
    localparam logic [11:0] EXT_BASE = 12'h800;

    // Register indices as printed
    localparam logic [9:0] IDX_CURSOR_MODE_DIRECT = 10'h009;
    localparam logic [9:0] IDX_CURSOR_X_LOW = 10'h00C;
    localparam logic [9:0] IDX_CURSOR_X_HIGH = 10'h00D;
    localparam logic [9:0] IDX_CURSOR_Y_LOW = 10'h00E;
    localparam logic [9:0] IDX_CURSOR_Y_HIGH = 10'h00F;
    localparam logic [9:0] IDX_CURSOR_CTL_INDIRECT = 10'h006;
    localparam logic [9:0] IDX_KEY_AND_ZOOM_CONTROL = 10'h038;
    localparam logic [9:0] IDX_CURSOR_RAM_ADDR_LOW = 10'h000;
    localparam logic [9:0] IDX_BLOCK_STATUS = 10'h001;

    // Byte addresses
    localparam logic [11:0] A_CURSOR_MODE_DIRECT = DIR_BASE + {IDX_CURSOR_MODE_DIRECT, 2'b00};
    localparam logic [11:0] A_CURSOR_X_LOW = DIR_BASE + {IDX_CURSOR_X_LOW, 2'b00};
    localparam logic [11:0] A_CURSOR_X_HIGH = DIR_BASE + {IDX_CURSOR_X_HIGH, 2'b00};
    localparam logic [11:0] A_CURSOR_Y_LOW = DIR_BASE + {IDX_CURSOR_Y_LOW, 2'b00};
    localparam logic [11:0] A_CURSOR_Y_HIGH = DIR_BASE + {IDX_CURSOR_Y_HIGH, 2'b00};
    localparam logic [11:0] A_CURSOR_CTL_INDIRECT = IND_BASE + {IDX_CURSOR_CTL_INDIRECT, 2'b00};
    localparam logic [11:0] A_KEY_AND_ZOOM_CONTROL = IND_BASE + {IDX_KEY_AND_ZOOM_CONTROL, 2'b00};
    localparam logic [11:0] A_CURSOR_RAM_ADDR_LOW = EXT_BASE + {IDX_CURSOR_RAM_ADDR_LOW, 2'b00};
    localparam logic [11:0] A_BLOCK_STATUS = EXT_BASE + {IDX_BLOCK_STATUS, 2'b00};

    // Reset values
    localparam logic [1:0] RST_CURSOR_MODE_DIRECT = 2'h0;
    localparam logic [7:0] RST_CURSOR_CTL_INDIRECT = 8'h00;
    localparam logic [7:0] RST_KEY_AND_ZOOM_CONTROL = 8'h10;
    localparam logic [7:0] RST_CURSOR_RAM_ADDR_LOW = 8'h00;
    localparam logic [11:0] RST_CURSOR_POS = 12'h000;

    // Cursor mode codes
    localparam logic [1:0] CUR_MODE_OFF = 2'h0;
    localparam logic [1:0] CUR_MODE_THREE_COLOUR = 2'h1;
    localparam logic [1:0] CUR_MODE_WIDE_STYLE = 2'h2;
    localparam logic [1:0] CUR_MODE_WINDOWS_STYLE = 2'h3;

    // Field positions
    localparam int CMODE_LSB = 0;
    localparam int CSRC_BIT = 7;
    localparam int CRAM_HI_LSB = 2;
    localparam int ZOOM_LSB = 5;
    localparam int KEY_POL_BIT = 4;
    localparam int POS_LOW_W = 8;
    localparam int POS_HIGH_W = 4;
    localparam int POS_W = 12;

    // Zoom codes
    localparam logic [2:0] ZOOM_MAX_CODE = 3'h5;
    localparam logic [2:0] ZOOM_ONE = 3'h0;

    // APB answers
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

    typedef logic [2:0] cckr_zoom_code_t;

endpackage

// >>> shared/cckr_zoom_if.sv
`timescale 1ns/1ps
interface cckr_zoom_if;
    import cckr_pkg::*;

    cckr_zoom_code_t zoom_code;
    logic vga_path;
    logic pix_tick;
    logic load_en;
    cckr_zoom_code_t zoom_shift;

    modport cfg (
        output zoom_code,
        output vga_path,
        output pix_tick,
        input load_en,
        input zoom_shift
    );

    modport zoom (
        input zoom_code,
        input vga_path,
        input pix_tick,
        output load_en,
        output zoom_shift
    );
endinterface

// >>> design/cckr_zoom.sv
`timescale 1ns/1ps
module cckr_zoom
    import cckr_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Zoom link
    cckr_zoom_if.zoom zif
);

    typedef struct packed {
        cckr_zoom_code_t shift;
        logic [4:0] cnt;
        logic load_en;
    } cckr_zoom_st_t;

    cckr_zoom_st_t st_r;
    cckr_zoom_st_t st_nxt;
    cckr_zoom_code_t shift_dec;
    logic [4:0] lim;

    always_comb begin
        // Undefined codes fall back to unity
        if (zif.zoom_code > ZOOM_MAX_CODE) begin
            shift_dec = ZOOM_ONE;
        end else begin
            shift_dec = zif.zoom_code;
        end
        // Legacy input path never zoomed
        if (zif.vga_path) begin
            shift_dec = ZOOM_ONE;
        end
        lim = 5'((6'h01 << shift_dec) - 6'h01);
        st_nxt = st_r;
        st_nxt.load_en = 1'b0;
        st_nxt.shift = shift_dec;
        if (shift_dec != st_r.shift) begin
            st_nxt.cnt = 5'h00;
        end else if (zif.pix_tick) begin
            // One load per factor of input ticks
            if (st_r.cnt >= lim) begin
                st_nxt.cnt = 5'h00;
                st_nxt.load_en = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign zif.load_en = st_r.load_en;
    assign zif.zoom_shift = st_r.shift;

endmodule

// >>> design/cckr_regs.sv
`timescale 1ns/1ps
module cckr_regs
    import cckr_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pixel path
    input wire logic pixel_tick,
    input wire logic vga_path_sel,
    output logic pixel_load_en,
    output logic [2:0] zoom_shift,
    // Cursor outputs
    output logic [1:0] cursor_mode,
    output logic cursor_visible,
    output logic [POS_W-1:0] cursor_lr_x,
    output logic [POS_W-1:0] cursor_lr_y,
    output logic [9:0] cursor_ram_addr,
    // Colour key outputs
    output logic key_polarity,
    output logic [3:0] compare_en
);

    typedef struct packed {
        logic [1:0] dcc_mode;
        logic [7:0] ccr;
        logic [7:0] ram_lo;
        logic [POS_W-1:0] pos_x;
        logic [POS_W-1:0] pos_y;
        logic [7:0] kzc;
        logic [1:0] mode_eff;
        logic visible;
        logic [9:0] ram_addr;
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic slverr;
    } cckr_regs_st_t;

    cckr_regs_st_t st_r;
    cckr_regs_st_t st_nxt;
    cckr_zoom_if zif ();

    logic setup_ph;
    logic wr_take;
    logic hit;
    logic ro_hit;
    logic [DATA_W-1:0] rd_val;
    logic [7:0] wbyte;

    assign setup_ph = psel && !penable;
    assign wr_take = psel && penable && st_r.ready && pwrite && !st_r.slverr;
    assign wbyte = pwdata[7:0];

    // Read decode
    always_comb begin
        rd_val = RDATA_NONE;
        hit = 1'b1;
        ro_hit = 1'b0;
        if (paddr == A_CURSOR_MODE_DIRECT) begin
            rd_val[1:0] = st_r.dcc_mode;
        end else if (paddr == A_CURSOR_X_LOW) begin
            rd_val[POS_LOW_W-1:0] = st_r.pos_x[POS_LOW_W-1:0];
        end else if (paddr == A_CURSOR_X_HIGH) begin
            rd_val[POS_HIGH_W-1:0] = st_r.pos_x[POS_W-1:POS_LOW_W];
        end else if (paddr == A_CURSOR_Y_LOW) begin
            rd_val[POS_LOW_W-1:0] = st_r.pos_y[POS_LOW_W-1:0];
        end else if (paddr == A_CURSOR_Y_HIGH) begin
            rd_val[POS_HIGH_W-1:0] = st_r.pos_y[POS_W-1:POS_LOW_W];
        end else if (paddr == A_CURSOR_CTL_INDIRECT) begin
            rd_val[7:0] = st_r.ccr;
        end else if (paddr == A_KEY_AND_ZOOM_CONTROL) begin
            rd_val[7:0] = st_r.kzc;
        end else if (paddr == A_CURSOR_RAM_ADDR_LOW) begin
            rd_val[7:0] = st_r.ram_lo;
        end else if (paddr == A_BLOCK_STATUS) begin
            rd_val[1:0] = st_r.mode_eff;
            rd_val[2] = st_r.visible;
            rd_val[5:3] = zif.zoom_shift;
            rd_val[15:6] = st_r.ram_addr;
            ro_hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // Next state
    always_comb begin
        st_nxt = st_r;
        // Zero wait: ready in the first access cycle
        st_nxt.ready = setup_ph;
        if (setup_ph) begin
            st_nxt.rdata = pwrite ? RDATA_NONE : rd_val;
            st_nxt.slverr = !hit || (pwrite && ro_hit);
        end else if (psel && penable && st_r.ready) begin
            st_nxt.rdata = RDATA_NONE;
            st_nxt.slverr = 1'b0;
        end
        // Writes take effect at the completing edge, no display wait
        if (wr_take) begin
            if (paddr == A_CURSOR_MODE_DIRECT) begin
                st_nxt.dcc_mode = wbyte[CMODE_LSB +: 2];
            end else if (paddr == A_CURSOR_X_LOW) begin
                st_nxt.pos_x[POS_LOW_W-1:0] = wbyte;
            end else if (paddr == A_CURSOR_X_HIGH) begin
                st_nxt.pos_x[POS_W-1:POS_LOW_W] = wbyte[POS_HIGH_W-1:0];
            end else if (paddr == A_CURSOR_Y_LOW) begin
                st_nxt.pos_y[POS_LOW_W-1:0] = wbyte;
            end else if (paddr == A_CURSOR_Y_HIGH) begin
                st_nxt.pos_y[POS_W-1:POS_LOW_W] = wbyte[POS_HIGH_W-1:0];
            end else if (paddr == A_CURSOR_CTL_INDIRECT) begin
                st_nxt.ccr = wbyte;
            end else if (paddr == A_KEY_AND_ZOOM_CONTROL) begin
                st_nxt.kzc = wbyte;
            end else if (paddr == A_CURSOR_RAM_ADDR_LOW) begin
                st_nxt.ram_lo = wbyte;
            end
        end
        // Effective cursor mode source
        if (st_nxt.ccr[CSRC_BIT]) begin
            st_nxt.mode_eff = st_nxt.dcc_mode;
        end else begin
            st_nxt.mode_eff = st_nxt.ccr[CMODE_LSB +: 2];
        end
        // Zero in either coordinate parks the cursor off screen
        st_nxt.visible = (st_nxt.mode_eff != CUR_MODE_OFF)
            && (st_nxt.pos_x != RST_CURSOR_POS)
            && (st_nxt.pos_y != RST_CURSOR_POS);
        st_nxt.ram_addr = {st_nxt.ccr[CRAM_HI_LSB +: 2], st_nxt.ram_lo};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.dcc_mode <= RST_CURSOR_MODE_DIRECT;
            st_r.ccr <= RST_CURSOR_CTL_INDIRECT;
            st_r.ram_lo <= RST_CURSOR_RAM_ADDR_LOW;
            st_r.pos_x <= RST_CURSOR_POS;
            st_r.pos_y <= RST_CURSOR_POS;
            st_r.kzc <= RST_KEY_AND_ZOOM_CONTROL;
            st_r.mode_eff <= CUR_MODE_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Zoom divider link
    assign zif.zoom_code = st_r.kzc[ZOOM_LSB +: 3];
    assign zif.vga_path = vga_path_sel;
    assign zif.pix_tick = pixel_tick;

    cckr_zoom u_zoom (
        .pclk(pclk),
        .presetn(presetn),
        .zif(zif)
    );

    // Outputs
    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.slverr;
    assign pixel_load_en = zif.load_en;
    assign zoom_shift = zif.zoom_shift;
    assign cursor_mode = st_r.mode_eff;
    assign cursor_visible = st_r.visible;
    // Stored values are the lower right corner coordinate
    assign cursor_lr_x = st_r.pos_x;
    assign cursor_lr_y = st_r.pos_y;
    assign cursor_ram_addr = st_r.ram_addr;
    assign key_polarity = st_r.kzc[KEY_POL_BIT];
    assign compare_en = st_r.kzc[3:0];

endmodule

// >>> bench/cckr_regs_properties.sv
`timescale 1ns/1ps
module cckr_regs_properties
    import cckr_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pixel path
    input wire logic pixel_tick,
    input wire logic vga_path_sel,
    input wire logic pixel_load_en,
    input wire logic [2:0] zoom_shift,
    // Cursor and key
    input wire logic [1:0] cursor_mode,
    input wire logic cursor_visible,
    input wire logic [POS_W-1:0] cursor_lr_x,
    input wire logic [POS_W-1:0] cursor_lr_y,
    input wire logic [9:0] cursor_ram_addr,
    input wire logic key_polarity,
    input wire logic [3:0] compare_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_key_write;
        psel && penable && pready && pwrite && paddr == A_KEY_AND_ZOOM_CONTROL;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_in_access: assert property (
        pready |-> psel && penable && !$past(penable))
        else $error("ready outside access");
    a_rdata_idle_zero: assert property (!pready |-> prdata == RDATA_NONE)
        else $error("read data outside answer");
    a_key_write_lands: assert property (
        s_key_write |=> {key_polarity, compare_en} == 5'($past(pwdata)))
        else $error("key control not updated");
    a_zoom_in_range: assert property (zoom_shift <= ZOOM_MAX_CODE)
        else $error("zoom beyond range");
    a_vga_not_zoomed: assert property (
        vga_path_sel [*3] |-> zoom_shift == ZOOM_ONE)
        else $error("legacy path zoomed");
    a_load_needs_tick: assert property (!pixel_tick |=> !pixel_load_en)
        else $error("load without tick");
    a_hidden_at_zero: assert property (
        (cursor_lr_x == 0 || cursor_lr_y == 0 || cursor_mode == CUR_MODE_OFF) [*2]
        |-> !cursor_visible)
        else $error("cursor shown at zero");
endmodule
bind cckr_regs cckr_regs_properties cckr_regs_properties_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pixel_tick(pixel_tick),
    .vga_path_sel(vga_path_sel), .pixel_load_en(pixel_load_en), .zoom_shift(zoom_shift),
    .cursor_visible(cursor_visible), .key_polarity(key_polarity), .cursor_mode(cursor_mode),
    .cursor_lr_x(cursor_lr_x), .cursor_lr_y(cursor_lr_y), .cursor_ram_addr(cursor_ram_addr),
    .compare_en(compare_en));

// >>> bench/cckr_regs_tb.sv
`timescale 1ns/1ps
module cckr_regs_tb
    import cckr_pkg::*;
;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} cckr_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pixel_tick, vga_path_sel;
    logic pixel_load_en, cursor_visible, key_polarity, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] zoom_shift;
    logic [1:0] cursor_mode;
    logic [11:0] cursor_lr_x, cursor_lr_y;
    logic [9:0] cursor_ram_addr;
    logic [3:0] compare_en;
    int err_total, tests_run, cnt;
    cckr_row_t rows [8] = '{'{A_CURSOR_MODE_DIRECT, 32'hFF, 32'h03, 1'b0},
        '{A_CURSOR_X_LOW, 32'hAB, 32'hAB, 1'b0}, '{A_CURSOR_X_HIGH, 32'hFF, 32'h0F, 1'b0},
        '{A_CURSOR_Y_LOW, 32'h01, 32'h01, 1'b0}, '{A_CURSOR_Y_HIGH, 32'hF0, 32'h00, 1'b0},
        '{A_KEY_AND_ZOOM_CONTROL, 32'hFF, 32'hFF, 1'b0},
        '{A_CURSOR_CTL_INDIRECT, 32'h80, 32'h80, 1'b0}, '{12'hFF0, 32'h55, 32'h00, 1'b1}};
    cckr_regs cckr_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pixel_tick(pixel_tick), .vga_path_sel(vga_path_sel),
        .pixel_load_en(pixel_load_en), .zoom_shift(zoom_shift), .cursor_mode(cursor_mode),
        .cursor_visible(cursor_visible), .cursor_lr_x(cursor_lr_x), .cursor_lr_y(cursor_lr_y),
        .cursor_ram_addr(cursor_ram_addr), .key_polarity(key_polarity), .compare_en(compare_en));
    always #4 pclk = ~pclk;
    task final_report;
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            final_report();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    initial begin
        idle(20000);
        err_total++;
        final_report();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, pixel_tick, vga_path_sel} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_total = 0;
        tests_run = 0;
        idle(3);
        chk("rst_mode", cursor_mode, 0);
        chk("rst_key", {key_polarity, compare_en}, 5'h10);
        presetn <= 1'b1;
        idle(1);
        apb(1'b0, A_KEY_AND_ZOOM_CONTROL, 0);
        chk("rst_key_rd", rd, 32'h10);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, rows[i].a, rows[i].w);
            chk("wr_err", er, rows[i].e);
            apb(1'b0, rows[i].a, 0);
            chk("rd_data", rd, rows[i].r);
            chk("rd_err", er, rows[i].e);
        end
        idle(3);
        chk("pos", {cursor_lr_x, cursor_lr_y}, 24'hFAB001);
        chk("direct_sel", {cursor_mode, cursor_visible, compare_en}, 7'h7F);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, A_KEY_AND_ZOOM_CONTROL, {24'h0, c[2:0], 5'h10});
            idle(3);
            chk("zoom", zoom_shift, (c > 5) ? 0 : c);
            chk("key", {key_polarity, compare_en}, 5'h10);
            cnt = 0;
            pixel_tick <= 1'b1;
            for (int k = 0; k < 66; k++) begin
                @(posedge pclk);
                if (k == 63) pixel_tick <= 1'b0;
                cnt += int'(pixel_load_en);
            end
            chk("loads", cnt, 64 >> ((c > 5) ? 0 : c));
        end
        apb(1'b1, A_KEY_AND_ZOOM_CONTROL, 32'hAF);
        vga_path_sel <= 1'b1;
        idle(4);
        chk("vga", {zoom_shift, key_polarity, compare_en}, 8'h0F);
        vga_path_sel <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, A_CURSOR_MODE_DIRECT, m);
            idle(3);
            chk("mode", cursor_mode, m);
        end
        apb(1'b1, A_CURSOR_CTL_INDIRECT, 32'h0E);
        apb(1'b1, A_CURSOR_RAM_ADDR_LOW, 32'h5A);
        idle(3);
        chk("ind_mode", {cursor_mode, cursor_ram_addr}, 12'hB5A);
        apb(1'b0, A_BLOCK_STATUS, 0);
        chk("status", rd, 32'hD6AE);
        apb(1'b1, A_BLOCK_STATUS, 0);
        chk("status_wr", er, 1);
        apb(1'b1, A_CURSOR_X_LOW, 0);
        apb(1'b1, A_CURSOR_X_HIGH, 0);
        idle(3);
        chk("hidden", {cursor_visible, cursor_lr_x}, 0);
        // Host adds offset to upper-left corner
        apb(1'b1, A_CURSOR_X_LOW, (32'h2C0 + 32'h40) & 32'hFF);
        apb(1'b1, A_CURSOR_X_HIGH, (32'h2C0 + 32'h40) >> 8);
        apb(1'b1, A_CURSOR_Y_LOW, (32'h1C0 + 32'h40) & 32'hFF);
        apb(1'b1, A_CURSOR_Y_HIGH, (32'h1C0 + 32'h40) >> 8);
        idle(3);
        chk("ul_pos", {cursor_lr_x, cursor_lr_y}, 24'h300200);
        chk("ul_vis", cursor_visible, 1);
        presetn <= 1'b0;
        idle(2);
        chk("rerst", {cursor_mode, key_polarity, compare_en}, 7'h10);
        presetn <= 1'b1;
        idle(1);
        apb(1'b0, A_CURSOR_MODE_DIRECT, 0);
        chk("rerst_rd", rd, 0);
        apb(1'b1, A_CURSOR_MODE_DIRECT, 32'h01);
        idle(3);
        chk("rerst_src", cursor_mode, 0);
        final_report();
    end
endmodule
